/* tx_parallel_input_phase_align.sv */
`timescale 1ns/1ps
module tx_parallel_input_phase_align (
    // Clocks and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tx_input_clock_first,
    // Static controls and the alignment reset
    input wire logic tx_clock_source_select,
    input wire logic tx_pll_rate_select,
    input wire logic [1:0] tx_encoder_mode,
    input wire logic tx_align_reset_n,
    // Characters from programmable logic
    input wire logic [1:0] tx_ctrl_field_a,
    input wire logic [1:0] tx_ctrl_field_b,
    input wire logic [1:0] tx_ctrl_field_c,
    input wire logic [1:0] tx_ctrl_field_d,
    input wire logic [7:0] tx_char_a,
    input wire logic [7:0] tx_char_b,
    input wire logic [7:0] tx_char_c,
    input wire logic [7:0] tx_char_d,
    // Encoder side
    input wire logic enc_ready,
    output logic enc_valid,
    output tx_align_pkg::enc_word_t enc_word,
    output logic [tx_align_pkg::CHANNELS-1:0] tx_path_error_flag
);
    import tx_align_pkg::*;

    typedef struct packed {
        word_t cap;
        logic cap_v;
        logic ovf_t;
    } link_s;

    typedef struct packed {
        align_st_e st;
        logic out_v;
        enc_word_t out;
        logic [CHANNELS-1:0] err;
        logic ovf_d;
        word_t direct;
    } core_s;

    link_s l_q, l_d;
    core_s q, d;
    word_t pins, rd_data, src;
    logic link_rst_n, wr_ready, rd_valid, rd_ready, src_v;
    logic [$clog2(FIFO_DEPTH):0] level;
    logic [3:0] stat_s;
    logic sel_s, rate_s, align_n_s, ovf_s;
    logic [1:0] mode_s;
    logic buf_en, align_act, ovf_ev, udf, load;
    logic [CHANNELS-1:0] sync_sent;

    assign pins = {{tx_ctrl_field_d, tx_char_d}, {tx_ctrl_field_c, tx_char_c},
                   {tx_ctrl_field_b, tx_char_b}, {tx_ctrl_field_a, tx_char_a}};
    assign {sel_s, rate_s, mode_s} = stat_s;

    function automatic enc_lane_s encode(lane_s ln, logic [1:0] mode);
        enc_lane_s e;
        e.bits = {2'h0, ln.chr};
        e.kind = KIND_DATA;
        if (mode == MODE_BYPASS) begin
            e.kind = KIND_RAW;
            e.bits = {ln.ctrl, ln.chr};
        end else begin
            case (ln.ctrl)
                CTRL_DATA: e.kind = KIND_DATA;
                CTRL_SPECIAL: e.kind = KIND_SPECIAL;
                CTRL_REPLACE: e.kind = KIND_REPLACE;
                default: e.kind = KIND_SYNC;
            endcase
        end
        return e;
    endfunction

    // ==========================================================
    // Crossings of control pins, reset and the overflow toggle
    bit_sync #(.WIDTH(1)) u_link_rst (
        .clock(tx_input_clock_first),
        .rst_n(rst_n),
        .d(1'b1),
        .q(link_rst_n)
    );

    bit_sync #(.WIDTH(4)) u_stat_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d({tx_clock_source_select, tx_pll_rate_select, tx_encoder_mode}),
        .q(stat_s)
    );

    // Resets to zero, so alignment is requested out of reset
    bit_sync #(.WIDTH(1)) u_align_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d(tx_align_reset_n),
        .q(align_n_s)
    );

    bit_sync #(.WIDTH(1)) u_ovf_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d(l_q.ovf_t),
        .q(ovf_s)
    );

    // ==========================================================
    // Link side capture on the first input clock
    always_comb begin
        l_d = l_q;
        l_d.cap = pins;
        l_d.cap_v = 1'b1;
        // Full buffer drops the word; the core sees a toggle
        if (l_q.cap_v && !wr_ready) begin
            l_d.ovf_t = ~l_q.ovf_t;
        end
    end

    always_ff @(posedge tx_input_clock_first or negedge link_rst_n) begin
        if (!link_rst_n) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    phase_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .wr_clock(tx_input_clock_first),
        .wr_rst_n(link_rst_n),
        .wr_valid(l_q.cap_v),
        .wr_ready(wr_ready),
        .wr_data(l_q.cap),
        .rd_clock(clock),
        .rd_rst_n(rst_n),
        .rd_valid(rd_valid),
        .rd_ready(rd_ready),
        .rd_data(rd_data),
        .rd_level(level)
    );

    // ==========================================================
    // Core side: alignment, encoding, error flags
    assign buf_en = sel_s | rate_s;
    assign align_act = !align_n_s && buf_en;
    assign ovf_ev = (ovf_s ^ q.ovf_d) && sel_s;
    assign load = !q.out_v || enc_ready;

    always_comb begin
        d = q;
        d.ovf_d = ovf_s;
        d.direct = pins;
        src = q.direct;
        src_v = 1'b0;
        rd_ready = 1'b1;
        udf = 1'b0;
        if (!sel_s) begin
            // Direct path: one sample of the pins per core clock edge
            src_v = 1'b1;
            d.st = ST_ALIGN;
        end else begin
            src = rd_data;
            case (q.st)
                ST_ALIGN: begin
                    // Drain above centre, wait below it
                    rd_ready = level > ALIGN_CENTRE;
                    if (!align_act && level >= ALIGN_CENTRE) begin
                        d.st = ST_RUN;
                    end
                end
                default: begin
                    rd_ready = load;
                    src_v = rd_valid;
                    udf = load && !rd_valid;
                    if (align_act) begin
                        d.st = ST_ALIGN;
                    end
                end
            endcase
        end
        sync_sent = '0;
        if (load) begin
            d.out_v = src_v;
            for (int i = 0; i < CHANNELS; i++) begin
                d.out[i] = encode(src[i], mode_s);
                sync_sent[i] = src_v && d.out[i].kind == KIND_SYNC;
            end
        end
        for (int i = 0; i < CHANNELS; i++) begin
            if (sync_sent[i] || align_act) begin
                d.err[i] = 1'b0;
            end
            // Set wins over a clear in the same cycle
            if ((udf || ovf_ev) && buf_en) begin
                d.err[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign enc_valid = q.out_v;
    assign enc_word = q.out;
    assign tx_path_error_flag = q.err;

    // ==========================================================
    // Checks
    logic [9:0] src0_raw, dir1_raw;
    assign src0_raw = {src[0].ctrl, src[0].chr};
    assign dir1_raw = {q.direct[1].ctrl, q.direct[1].chr};

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    property p_bypass_raw;
        load && src_v && mode_s == MODE_BYPASS |=>
            enc_word[0].kind == KIND_RAW &&
            enc_word[0].bits == $past(src0_raw);
    endproperty
    a_bypass_raw: assert property (p_bypass_raw)
        else $error("bypass lane not raw ten bits");

    property p_special_kind;
        load && src_v && mode_s != MODE_BYPASS &&
            src[0].ctrl == CTRL_SPECIAL |=> enc_word[0].kind == KIND_SPECIAL;
    endproperty
    a_special_kind: assert property (p_special_kind)
        else $error("special control not encoded as special");

    property p_char_named;
        load && src_v && mode_s != MODE_BYPASS |=>
            enc_word[0].bits[7:0] == $past(src[0].chr)
            && enc_word[0].kind != KIND_RAW;
    endproperty
    a_char_named: assert property (p_char_named)
        else $error("encoder character lost");

    property p_direct_capture;
        !sel_s && load && mode_s == MODE_BYPASS |=>
            enc_valid && enc_word[1].bits == $past(dir1_raw);
    endproperty
    a_direct_capture: assert property (p_direct_capture)
        else $error("reference capture not forwarded");

    property p_align_holds;
        sel_s && align_act |=> q.st == ST_ALIGN;
    endproperty
    a_align_holds: assert property (p_align_holds)
        else $error("buffer not realigning under align reset");

    property p_frozen;
        q.st == ST_RUN && sel_s && !align_act |=> q.st == ST_RUN;
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("phase not frozen after release");

    property p_ignored;
        !sel_s && !rate_s |=> tx_path_error_flag == $past(q.err);
    endproperty
    a_ignored: assert property (p_ignored)
        else $error("align reset interpreted while ignored");

    property p_align_clears;
        align_act && !udf && !ovf_ev |=> tx_path_error_flag == '0;
    endproperty
    a_align_clears: assert property (p_align_clears)
        else $error("align reset did not clear error flags");

    property p_err_set;
        (udf || ovf_ev) && buf_en |=> &tx_path_error_flag;
    endproperty
    a_err_set: assert property (p_err_set)
        else $error("buffer fault did not raise error flag");

    property p_err_sticky;
        q.err[0] && !align_act && !sync_sent[0] |=> tx_path_error_flag[0];
    endproperty
    a_err_sticky: assert property (p_err_sticky)
        else $error("error flag dropped without cause");

    c_run: cover property (sel_s && q.st == ST_ALIGN ##1 q.st == ST_RUN);
    c_underflow: cover property (udf ##1 &tx_path_error_flag);
    c_sync_clear: cover property (q.err[0] && sync_sent[0] ##1 !q.err[0]);
    c_overflow: cover property (ovf_ev);
endmodule // tx_parallel_input_phase_align

/* tx_align_pkg.sv */
package tx_align_pkg;

    // ==========================================================
    // Geometry
    localparam int CHANNELS = 4;
    localparam int FIFO_DEPTH = 16;
    localparam int ALIGN_CENTRE = FIFO_DEPTH / 2;

    // ==========================================================
    // Encoder mode and control field codes
    localparam logic [1:0] MODE_BYPASS = 2'h0;
    localparam logic [1:0] CTRL_DATA = 2'h0;
    localparam logic [1:0] CTRL_SPECIAL = 2'h1;
    localparam logic [1:0] CTRL_REPLACE = 2'h2;
    localparam logic [1:0] CTRL_WORD_SYNC = 2'h3;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [1:0] ctrl;
        logic [7:0] chr;
    } lane_s;
    typedef lane_s [CHANNELS-1:0] word_t;
    localparam int WORD_W = $bits(word_t);

    typedef enum logic [2:0] {
        KIND_RAW = 3'b000,
        KIND_DATA = 3'b001,
        KIND_SPECIAL = 3'b010,
        KIND_REPLACE = 3'b011,
        KIND_SYNC = 3'b100
    } kind_e;

    typedef struct packed {
        kind_e kind;
        logic [9:0] bits;
    } enc_lane_s;
    typedef enc_lane_s [CHANNELS-1:0] enc_word_t;

    typedef enum logic [0:0] {
        ST_ALIGN = 1'b0,
        ST_RUN = 1'b1
    } align_st_e;

endpackage

/* bit_sync.sv */
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    // ==========================================================
    // Two stages; first stage feeds only the second
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // bit_sync

/* phase_fifo.sv */
`timescale 1ns/1ps
module phase_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 16
) (
    // Write side
    input wire logic wr_clock,
    input wire logic wr_rst_n,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    // Read side
    input wire logic rd_clock,
    input wire logic rd_rst_n,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data,
    output logic [$clog2(DEPTH):0] rd_level
);
    localparam int AW = $clog2(DEPTH);
    typedef logic [AW:0] ptr_t;

    if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("phase_fifo depth must be a power of two, at least 4");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    ptr_t wbin_q, wgray_q, rbin_q, rgray_q, wgray_s, rgray_s;
    ptr_t wbin_d, rbin_d;

    function automatic ptr_t gray_to_bin(ptr_t g);
        ptr_t b;
        b = g;
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // ==========================================================
    // Write domain
    assign wbin_d = wbin_q + ptr_t'(1);
    assign wr_ready = wgray_q != {~rgray_s[AW:AW-1], rgray_s[AW-2:0]};

    always_ff @(posedge wr_clock) begin
        if (wr_valid && wr_ready) begin
            mem[wbin_q[AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge wr_clock or negedge wr_rst_n) begin
        if (!wr_rst_n) begin
            wbin_q <= '0;
            wgray_q <= '0;
        end else if (wr_valid && wr_ready) begin
            wbin_q <= wbin_d;
            wgray_q <= wbin_d ^ (wbin_d >> 1);
        end
    end

    // ==========================================================
    // Read domain
    assign rbin_d = rbin_q + ptr_t'(1);
    assign rd_valid = rgray_q != wgray_s;
    assign rd_data = mem[rbin_q[AW-1:0]];
    assign rd_level = gray_to_bin(wgray_s) - rbin_q;

    always_ff @(posedge rd_clock or negedge rd_rst_n) begin
        if (!rd_rst_n) begin
            rbin_q <= '0;
            rgray_q <= '0;
        end else if (rd_valid && rd_ready) begin
            rbin_q <= rbin_d;
            rgray_q <= rbin_d ^ (rbin_d >> 1);
        end
    end

    // ==========================================================
    // Gray pointer crossings
    bit_sync #(.WIDTH(AW + 1)) u_wptr_sync (
        .clock(rd_clock),
        .rst_n(rd_rst_n),
        .d(wgray_q),
        .q(wgray_s)
    );

    bit_sync #(.WIDTH(AW + 1)) u_rptr_sync (
        .clock(wr_clock),
        .rst_n(wr_rst_n),
        .d(rgray_q),
        .q(rgray_s)
    );
endmodule // phase_fifo

/* tx_char_source.sv */
`timescale 1ns/1ps
// ==========================================================
// Character source standing in for the programmable logic
module tx_char_source (
    // Link clock and reset
    input wire logic link_clock,
    input wire logic rst_n,
    // Requests from the bench
    input wire logic align_go,
    input wire logic [3:0] sync_mask,
    // Characters and alignment reset
    output tx_align_pkg::word_t word,
    output logic align_n
);
    import tx_align_pkg::*;

    logic [7:0] cnt_q;
    logic [1:0] low_q;

    // ==========================================================
    // Counting stream, one character per link edge
    always_ff @(posedge link_clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            low_q <= 2'h0;
            align_n <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            // Held low past the minimum so every lane sees it
            if (align_go && align_n) begin
                align_n <= 1'b0;
                low_q <= 2'h2;
            end else if (low_q != 2'h0) begin
                low_q <= low_q - 2'h1;
            end else begin
                align_n <= 1'b1;
            end
        end
    end

    always_comb begin
        for (int l = 0; l < CHANNELS; l++) begin
            word[l].chr = cnt_q + 8'(l * 16);
            word[l].ctrl = sync_mask[l] ? CTRL_WORD_SYNC : CTRL_DATA;
        end
    end
endmodule // tx_char_source

/* tx_parallel_input_phase_align_bench.sv */
`timescale 1ns/1ps
module tx_parallel_input_phase_align_bench;
    import tx_align_pkg::*;

    // ==========================================================
    // Clocks, pins and counters
    logic clock = 1'b0;
    logic link_clock = 1'b0;
    logic rst_n = 1'b0;
    logic sel = 1'b0;
    logic rate = 1'b0;
    logic [1:0] mode = 2'h0;
    logic align_b = 1'b1;
    logic align_go = 1'b0;
    logic [3:0] sync_mask = 4'h0;
    logic enc_ready = 1'b1;
    logic pace = 1'b0;
    logic chk_on = 1'b0;
    logic locked = 1'b0;
    logic ld = 1'b0;
    logic [2:0] pc = 3'h0;
    logic [31:0] seed = 32'h54a2_5566;
    word_t pins_b = '0;
    word_t pins_p;
    word_t pins;
    logic align_p;
    logic align_n;
    logic enc_valid;
    enc_word_t enc_word;
    logic [CHANNELS-1:0] flags;
    int bad_count = 0;
    int n_checks = 0;
    word_t q[$];
    word_t sent[$];

    assign pins = sel ? pins_p : pins_b;
    assign align_n = sel ? align_p : align_b;

    always #2 clock = ~clock;
    initial begin
        #1.3;
        forever #16 link_clock = ~link_clock;
    end

    tx_char_source tx_char_source_i (
        .link_clock(link_clock), .rst_n(rst_n), .align_go(align_go),
        .sync_mask(sync_mask), .word(pins_p), .align_n(align_p)
    );

    tx_parallel_input_phase_align tx_parallel_input_phase_align_i (
        .clock(clock), .rst_n(rst_n), .tx_input_clock_first(link_clock),
        .tx_clock_source_select(sel), .tx_pll_rate_select(rate),
        .tx_encoder_mode(mode), .tx_align_reset_n(align_n),
        .tx_ctrl_field_a(pins[0].ctrl), .tx_ctrl_field_b(pins[1].ctrl),
        .tx_ctrl_field_c(pins[2].ctrl), .tx_ctrl_field_d(pins[3].ctrl),
        .tx_char_a(pins[0].chr), .tx_char_b(pins[1].chr),
        .tx_char_c(pins[2].chr), .tx_char_d(pins[3].chr),
        .enc_ready(enc_ready), .enc_valid(enc_valid), .enc_word(enc_word),
        .tx_path_error_flag(flags)
    );

    // ==========================================================
    // Model and helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic enc_word_t expect_word(input logic [1:0] m,
                                              input word_t w);
        enc_word_t e;
        for (int l = 0; l < CHANNELS; l++) begin
            e[l].bits = {2'b00, w[l].chr};
            case (w[l].ctrl)
                CTRL_DATA: e[l].kind = KIND_DATA;
                CTRL_SPECIAL: e[l].kind = KIND_SPECIAL;
                CTRL_REPLACE: e[l].kind = KIND_REPLACE;
                default: e[l].kind = KIND_SYNC;
            endcase
            if (m == MODE_BYPASS) begin
                e[l].kind = KIND_RAW;
                e[l].bits = {w[l].ctrl, w[l].chr};
            end
        end
        return e;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] want,
                         input string what);
        n_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: %s seen %h want %h",
                     $time, what, seen, want);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Encoder paced at the link rate, one load in eight clocks
    always @(posedge clock) begin
        pc <= pc + 3'h1;
        ld <= enc_ready || !enc_valid;
        if (pace) begin
            enc_ready <= (pc == 3'h0);
        end
    end

    always @(posedge link_clock) begin
        if (sel) begin
            sent.push_back(pins_p);
        end
    end

    enc_word_t w_exp;

    always @(negedge clock) begin
        if (chk_on && ld && enc_valid) begin
            if (!locked) begin
                // Realignment may add or lose characters
                while (sent.size() > 1 &&
                       expect_word(mode, sent[0]) !== enc_word) begin
                    void'(sent.pop_front());
                end
                locked = 1'b1;
            end
            if (sent.size() > 0) begin
                w_exp = expect_word(mode, sent.pop_front());
                check(enc_word, w_exp, "link word");
            end else begin
                check(1'b0, 1'b1, "link word missing");
            end
        end
    end

    // ==========================================================
    // Scenarios
    task automatic run_core(input logic r, input logic [1:0] m);
        word_t w;
        enc_word_t w_core;
        @(posedge clock);
        rate <= r;
        mode <= m;
        q.delete();
        for (int i = 0; i < 48; i++) begin
            @(posedge clock);
            for (int l = 0; l < CHANNELS; l++) begin
                seed = lfsr(seed);
                w[l].chr = seed[7:0];
                w[l].ctrl = 2'(i + l);
            end
            pins_b <= w;
            align_b <= !(i >= 20 && i < 24);
            q.push_back(w);
            @(negedge clock);
            if (i >= 6) begin
                w_core = expect_word(m, q[i-2]);
                check(enc_word, w_core, "core");
                check({enc_valid, flags}, 5'h10, "fl");
            end
        end
    endtask

    task automatic realign();
        chk_on = 1'b0;
        @(posedge clock);
        align_go <= 1'b1;
        wait (!align_p);
        @(posedge clock);
        align_go <= 1'b0;
        repeat (8) @(posedge clock);
        check(flags, 4'h0, "flags while aligning");
        wait (align_p);
        repeat (150) @(posedge clock);
        locked = 1'b0;
        chk_on = 1'b1;
    endtask

    initial begin
        repeat (12) @(posedge clock);
        check({enc_valid, enc_word, flags}, '0, "reset state");
        rst_n <= 1'b1;
        run_core(1'b0, 2'h0);
        run_core(1'b0, 2'h1);
        run_core(1'b1, 2'h2);
        run_core(1'b1, 2'h3);
        @(posedge clock);
        rate <= 1'b0;
        mode <= 2'h1;
        sel <= 1'b1;
        pace <= 1'b1;
        realign();
        repeat (400) @(posedge clock);
        check(flags, 4'h0, "flags in run");
        // Stall the encoder until the buffer overflows
        chk_on = 1'b0;
        pace <= 1'b0;
        @(posedge clock);
        enc_ready <= 1'b0;
        repeat (200) @(posedge clock);
        check(flags, 4'hf, "overflow flags");
        enc_ready <= 1'b1;
        repeat (6) @(posedge clock);
        pace <= 1'b1;
        @(posedge link_clock);
        @(posedge clock);
        sync_mask <= 4'h1;
        @(posedge link_clock);
        @(posedge clock);
        sync_mask <= 4'h0;
        repeat (200) @(posedge clock);
        check(flags, 4'he, "sync clears lane");
        realign();
        repeat (400) @(posedge clock);
        check(flags, 4'h0, "flags after realign");
        test_done();
    end

    // Whole run needs about 7 us
    initial begin
        #40000;
        bad_count++;
        $display("wrong value at %0t: run did not finish", $time);
        test_done();
    end
endmodule // tx_parallel_input_phase_align_bench
